// ==== verilog/ring_cadence_consts.svh ====
// offsets, field positions, reset values and timing counts of the ringing bank
`ifndef RING_CADENCE_CONSTS_SVH
`define RING_CADENCE_CONSTS_SVH
// Operation
// - data write then address write stores the held word at next update
// - address write without data write loads the word at next update
// - low data byte holds bits 7:0, read/write, resets to zero
// - status bit 0 is high while a RAM access is pending
// - soft reset bit 1 resets channel B, bit 0 channel A
// - single channel soft reset defaults that channel only
// - both soft reset bits act as full reset with RAM clear
// - config bit 7 reads high while a ringing waveform is present
// - config bit 6 reads high when ringing goes to the diff converter
// - config bit 5 enables internal unbalanced ringing
// - config bit 4 enables the burst on-time timer
// - config bit 3 enables the silent interval timer
// - config bit 2 follows the ringing oscillator state
// - config bit 1 selects reverse polarity unbalanced ringing
// - config bit 0 selects sinusoid or trapezoid
// - on-time count sits at 24 and 25, 1.25 us per count; the code counts 13 clocks of 100 ns, 1.3 us
// - silent interval high byte sits at 27, resets to zero
// - silent interval low byte sits at 26
// - RAM word pointer sits at 103 and triggers accesses
// - high data byte at 102 holds bits 15:8

// register indices; byte address is four times the index
`define IDX_SOFT_RESET 8'h01
`define IDX_RAM_STAT   8'h04
`define IDX_RING_CFG   8'h17
`define IDX_ON_LO      8'h18
`define IDX_ON_HI      8'h19
`define IDX_OFF_LO     8'h1A
`define IDX_OFF_HI     8'h1B
`define IDX_DATA_LO    8'h65
`define IDX_DATA_HI    8'h66
`define IDX_RAM_PTR    8'h67

`define SR_CHAN_A 0
`define SR_CHAN_B 1
`define RC_PRESENT 7
`define RC_DIFF    6
`define RC_UNB     5
`define RC_ON_EN   4
`define RC_OFF_EN  3
`define RC_OSC     2
`define RC_REVPOL  1
`define RC_TRAP    0
`define RST_BYTE 8'h00

`define CLK_NS 100
`define TICK_NS 1250
`define TICK_CYC ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`define MEM_UPD_CYC 8
`endif

// ==== verilog/ring_cadence_pkg.sv ====
// types shared by the ringing cadence and RAM access bank
package ring_cadence_pkg;
    typedef enum logic [1:0] {
        CAD_IDLE = 2'b00,
        CAD_ON   = 2'b01,
        CAD_OFF  = 2'b11
    } cad_state_t;

    typedef enum logic [3:0] {
        SEL_NONE, SEL_SRST, SEL_STAT, SEL_RCFG, SEL_ONLO, SEL_ONHI,
        SEL_OFFLO, SEL_OFFHI, SEL_DLO, SEL_DHI, SEL_PTR
    } reg_sel_t;

    typedef struct packed {
        logic unb_en;
        logic on_en;
        logic off_en;
        logic rev_pol;
        logic trap;
    } ring_cfg_t;

    typedef struct packed {
        logic osc_on;
        logic unb_en;
        logic rev_pol;
        logic trap;
    } ring_out_t;
endpackage : ring_cadence_pkg

// ==== verilog/ring_cadence_ram_access_regs.sv ====
// ringing cadence, soft reset and indirect RAM access registers on AXI4-Lite
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "ring_cadence_consts.svh"
module ring_cadence_ram_access_regs (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [31:0]                  s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [31:0]                  s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic                         ring_request,
    input  wire logic                         ring_to_diff_converter,
    output ring_cadence_pkg::ring_out_t       ring_out,
    output logic                              pll_reinit,
    output logic                              soft_reset_chan_b
);
    import ring_cadence_pkg::*;

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    function automatic reg_sel_t dec(input logic [31:0] a);
        logic [7:0] i;
        i = a[9:2];
        dec = SEL_NONE;
        if (a[31:10] == 22'h0) begin
            case (i)
                `IDX_SOFT_RESET: dec = SEL_SRST;
                `IDX_RAM_STAT:   dec = SEL_STAT;
                `IDX_RING_CFG:   dec = SEL_RCFG;
                `IDX_ON_LO:      dec = SEL_ONLO;
                `IDX_ON_HI:      dec = SEL_ONHI;
                `IDX_OFF_LO:     dec = SEL_OFFLO;
                `IDX_OFF_HI:     dec = SEL_OFFHI;
                `IDX_DATA_LO:    dec = SEL_DLO;
                `IDX_DATA_HI:    dec = SEL_DHI;
                `IDX_RAM_PTR:    dec = SEL_PTR;
                default:         dec = SEL_NONE;
            endcase
        end
    endfunction : dec

    logic             aw_v_q, aw_v_d, w_v_q, w_v_d, bv_q, bv_d, rv_q, rv_d;
    logic [31:0]      aw_a_q, aw_a_d;
    logic [7:0]       w_d_q, w_d_d;
    logic             w_s_q, w_s_d;
    logic [1:0]       br_q, br_d, rr_q, rr_d;
    logic [31:0]      rd_q, rd_d;
    logic             wr_fire, wen, srst_a, srst_b, busy;
    reg_sel_t         wsel, rsel;
    logic [7:0]       wdat;

    logic [15:0]      mem [256];
    logic [15:0]      dat_q, dat_d;
    logic [7:0]       ptr_q, ptr_d, clr_q, clr_d, mem_wa;
    logic             pend_q, pend_d, wrop_q, wrop_d, dwr_q, dwr_d;
    logic             clring_q, clring_d, mem_we, upd_tick;
    logic [2:0]       upd_q, upd_d;
    logic [15:0]      mem_wd;

    ring_cfg_t        cfg_q, cfg_d;
    logic [15:0]      ta_q, ta_d, ti_q, ti_d;
    logic             pll_q, pll_d, chb_q, chb_d;

    cad_state_t       st_q, st_d;
    logic [3:0]       tick_q, tick_d;
    logic [15:0]      cnt_q, cnt_d, cnt_nx;
    logic             tick_end, osc_on;

    // -----------------------------------------------------------------
    // bus slave
    // -----------------------------------------------------------------
    // address and data are parked separately so either may come first
    assign s_axi_awready = ~aw_v_q & ~bv_q;
    assign s_axi_wready  = ~w_v_q & ~bv_q;
    assign s_axi_arready = ~rv_q;
    assign wr_fire = aw_v_q & w_v_q & ~bv_q;
    assign wsel    = dec(aw_a_q);
    assign wdat    = w_d_q;
    assign wen     = wr_fire & w_s_q & (wsel != SEL_NONE);
    assign rsel    = dec(s_axi_araddr);
    assign srst_a  = wen & (wsel == SEL_SRST) & wdat[`SR_CHAN_A];
    assign srst_b  = wen & (wsel == SEL_SRST) & wdat[`SR_CHAN_B];
    assign busy    = pend_q | clring_q;
    assign osc_on  = (st_q == CAD_ON);

    always_comb begin
        aw_v_d = aw_v_q;
        aw_a_d = aw_a_q;
        w_v_d  = w_v_q;
        w_d_d  = w_d_q;
        w_s_d  = w_s_q;
        bv_d   = bv_q;
        br_d   = br_q;
        rv_d   = rv_q;
        rr_d   = rr_q;
        rd_d   = rd_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_v_d = 1'b1;
            aw_a_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_v_d = 1'b1;
            w_d_d = s_axi_wdata[7:0];
            w_s_d = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_v_d = 1'b0;
            w_v_d  = 1'b0;
            bv_d   = 1'b1;
            br_d   = (wsel == SEL_NONE) ? 2'h2 : 2'h0;
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rr_d = (rsel == SEL_NONE) ? 2'h2 : 2'h0;
            rd_d = 32'h0;
            case (rsel)
                SEL_STAT:  rd_d[0] = busy;
                SEL_RCFG:  rd_d[7:0] = {osc_on,
                                        ring_to_diff_converter,
                                        cfg_q.unb_en, cfg_q.on_en, cfg_q.off_en,
                                        osc_on,
                                        cfg_q.rev_pol, cfg_q.trap};
                SEL_ONLO:  rd_d[7:0] = ta_q[7:0];
                SEL_ONHI:  rd_d[7:0] = ta_q[15:8];
                SEL_OFFLO: rd_d[7:0] = ti_q[7:0];
                SEL_OFFHI: rd_d[7:0] = ti_q[15:8];
                SEL_DLO:   rd_d[7:0] = dat_q[7:0];
                SEL_DHI:   rd_d[7:0] = dat_q[15:8];
                SEL_PTR:   rd_d[7:0] = ptr_q;
                default:   rd_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_v_q <= 1'b0;
            aw_a_q <= 32'h0;
            w_v_q  <= 1'b0;
            w_d_q  <= 8'h00;
            w_s_q  <= 1'b0;
            bv_q   <= 1'b0;
            br_q   <= 2'h0;
            rv_q   <= 1'b0;
            rr_q   <= 2'h0;
            rd_q   <= 32'h0;
        end else begin
            aw_v_q <= aw_v_d;
            aw_a_q <= aw_a_d;
            w_v_q  <= w_v_d;
            w_d_q  <= w_d_d;
            w_s_q  <= w_s_d;
            bv_q   <= bv_d;
            br_q   <= br_d;
            rv_q   <= rv_d;
            rr_q   <= rr_d;
            rd_q   <= rd_d;
        end
    end

    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp  = br_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rresp  = rr_q;
    assign s_axi_rdata  = rd_q;

    // -----------------------------------------------------------------
    // indirect RAM access
    // -----------------------------------------------------------------
    // pointer writes while busy are dropped so a pending access is never lost
    assign upd_tick = (upd_q == 3'(`MEM_UPD_CYC - 1));

    always_comb begin
        dat_d    = dat_q;
        ptr_d    = ptr_q;
        pend_d   = pend_q;
        wrop_d   = wrop_q;
        dwr_d    = dwr_q;
        clr_d    = clr_q;
        clring_d = clring_q;
        upd_d    = upd_tick ? 3'h0 : upd_q + 3'h1;
        mem_we   = 1'b0;
        mem_wa   = ptr_q;
        mem_wd   = dat_q;
        if (clring_q) begin
            mem_we = 1'b1;
            mem_wa = clr_q;
            mem_wd = 16'h0000;
            clr_d  = clr_q + 8'h01;
            if (clr_q == 8'hFF) begin
                clring_d = 1'b0;
            end
        end else if (upd_tick && pend_q) begin
            pend_d = 1'b0;
            if (wrop_q) begin
                mem_we = 1'b1;
            end else begin
                dat_d = mem[ptr_q];
            end
        end
        if (wen && wsel == SEL_DLO) begin
            dat_d[7:0] = wdat;
            dwr_d      = 1'b1;
        end
        if (wen && wsel == SEL_DHI) begin
            dat_d[15:8] = wdat;
            dwr_d       = 1'b1;
        end
        if (wen && wsel == SEL_PTR && !busy) begin
            ptr_d  = wdat;
            pend_d = 1'b1;
            wrop_d = dwr_q;
            dwr_d  = 1'b0;
        end
        if (srst_a && srst_b) begin
            clring_d = 1'b1;
            clr_d    = 8'h00;
            dat_d    = 16'h0000;
            ptr_d    = `RST_BYTE;
            pend_d   = 1'b0;
            dwr_d    = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        if (rst) begin
            dat_q    <= 16'h0000;
            ptr_q    <= `RST_BYTE;
            pend_q   <= 1'b0;
            wrop_q   <= 1'b0;
            dwr_q    <= 1'b0;
            clr_q    <= 8'h00;
            clring_q <= 1'b1;
            upd_q    <= 3'h0;
        end else begin
            dat_q    <= dat_d;
            ptr_q    <= ptr_d;
            pend_q   <= pend_d;
            wrop_q   <= wrop_d;
            dwr_q    <= dwr_d;
            clr_q    <= clr_d;
            clring_q <= clring_d;
            upd_q    <= upd_d;
        end
    end

    // -----------------------------------------------------------------
    // ringing configuration and timers
    // -----------------------------------------------------------------
    // soft reset bits self clear, so the register always reads zero
    always_comb begin
        cfg_d = cfg_q;
        ta_d  = ta_q;
        ti_d  = ti_q;
        pll_d = srst_a & srst_b;
        chb_d = srst_b & ~srst_a;
        if (wen && wsel == SEL_RCFG) begin
            cfg_d.unb_en  = wdat[`RC_UNB];
            cfg_d.on_en   = wdat[`RC_ON_EN];
            cfg_d.off_en  = wdat[`RC_OFF_EN];
            cfg_d.rev_pol = wdat[`RC_REVPOL];
            cfg_d.trap    = wdat[`RC_TRAP];
        end
        if (wen && wsel == SEL_ONLO) ta_d[7:0] = wdat;
        if (wen && wsel == SEL_ONHI) ta_d[15:8] = wdat;
        if (wen && wsel == SEL_OFFLO) ti_d[7:0] = wdat;
        if (wen && wsel == SEL_OFFHI) ti_d[15:8] = wdat;
        if (srst_a) begin
            cfg_d = '0;
            ta_d  = 16'h0000;
            ti_d  = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= '0;
            ta_q  <= 16'h0000;
            ti_q  <= 16'h0000;
            pll_q <= 1'b0;
            chb_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            ta_q  <= ta_d;
            ti_q  <= ti_d;
            pll_q <= pll_d;
            chb_q <= chb_d;
        end
    end

    assign pll_reinit        = pll_q;
    assign soft_reset_chan_b = chb_q;
    assign ring_out          = '{osc_on, cfg_q.unb_en, cfg_q.rev_pol, cfg_q.trap};

    // -----------------------------------------------------------------
    // cadence
    // -----------------------------------------------------------------
    // a disabled timer never expires: the phase lasts until ring_request drops
    assign tick_end = (tick_q == 4'(`TICK_CYC - 1));
    assign cnt_nx   = cnt_q + 16'h0001;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        tick_d = tick_end ? 4'h0 : tick_q + 4'h1;
        if (tick_end) begin
            cnt_d = cnt_nx;
        end
        unique case (st_q)
            CAD_IDLE: begin
                cnt_d  = 16'h0000;
                tick_d = 4'h0;
                if (ring_request) st_d = CAD_ON;
            end
            CAD_ON: begin
                if (!ring_request) begin
                    st_d = CAD_IDLE;
                end else if (cfg_q.on_en && tick_end && cnt_nx >= ta_q) begin
                    st_d  = CAD_OFF;
                    cnt_d = 16'h0000;
                end
            end
            CAD_OFF: begin
                if (!ring_request) begin
                    st_d = CAD_IDLE;
                end else if (cfg_q.off_en && tick_end && cnt_nx >= ti_q) begin
                    st_d  = CAD_ON;
                    cnt_d = 16'h0000;
                end
            end
            default: st_d = CAD_IDLE;
        endcase
        if (srst_a) begin
            st_d = CAD_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= CAD_IDLE;
            tick_q <= 4'h0;
            cnt_q  <= 16'h0000;
        end else begin
            st_q   <= st_d;
            tick_q <= tick_d;
            cnt_q  <= cnt_d;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ptr_wr;
        wen && wsel == SEL_PTR && !busy && !srst_a;
    endsequence
    sequence s_upd_done;
        ##[0:8] !pend_q;
    endsequence
    sequence s_rd_cfg;
        s_axi_arvalid && s_axi_arready && rsel == SEL_RCFG;
    endsequence

    chk_busy_window: assert property (s_ptr_wr |=> busy ##0 s_upd_done)
        else $error("ram busy flag wrong around pointer write");
    chk_ram_store: assert property (upd_tick && pend_q && wrop_q && !clring_q
        |=> mem[$past(ptr_q)] == $past(dat_q))
        else $error("ram word not stored at update");
    chk_ram_fetch: assert property (upd_tick && pend_q && !wrop_q && !clring_q
        && !wen |=> dat_q == $past(mem[ptr_q]))
        else $error("ram word not fetched at update");
    chk_data_low: assert property (wen && wsel == SEL_DLO && !srst_a
        |=> dat_q[7:0] == $past(wdat) && dwr_q)
        else $error("low data byte not held");
    chk_chan_a_rst: assert property (srst_a && !srst_b
        |=> cfg_q == '0 && ta_q == 16'h0000 && st_q == CAD_IDLE
        && ptr_q == $past(ptr_q) && !pll_reinit)
        else $error("channel soft reset wrong");
    chk_full_rst: assert property (srst_a && srst_b
        |=> pll_reinit && clring_q && clr_q == 8'h00 ##1 clring_q [*8])
        else $error("full reset did not clear ram");
    // both bits were latched from the state one cycle before rdata rose
    chk_osc_bit: assert property (s_rd_cfg
        |=> s_axi_rdata[`RC_OSC] == $past(osc_on)
        && s_axi_rdata[`RC_PRESENT] == $past(ring_out.osc_on))
        else $error("oscillator bit does not follow state");
    chk_cfg_bits: assert property (wen && wsel == SEL_RCFG && !srst_a
        |=> ring_out.unb_en == $past(wdat[`RC_UNB])
        && ring_out.trap == $past(wdat[`RC_TRAP]))
        else $error("config bits not applied");
    chk_burst_end: assert property (osc_on && ring_request && cfg_q.on_en
        && tick_end && cnt_nx >= ta_q && !srst_a |=> st_q == CAD_OFF)
        else $error("burst did not end at on-time");
    chk_gap_end: assert property (st_q == CAD_OFF && ring_request && cfg_q.off_en
        && tick_end && cnt_nx >= ti_q && !srst_a |=> osc_on)
        else $error("silence did not end at off-time");
endmodule : ring_cadence_ram_access_regs

// ==== dv/test_ring_cadence_ram_access_regs.sv ====
// self-checking bench for the ringing cadence and RAM access register bank
`timescale 1ns/1ps
module test_ring_cadence_ram_access_regs;
    import ring_cadence_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, pll_reinit, soft_reset_chan_b;
    logic [1:0]  bresp, rresp;
    logic        ring_request = 1'b0, ring_to_diff_converter = 1'b1;
    ring_out_t   ring_out;
    int          n_mismatch = 0, tests_run = 0, n_pll = 0, n_srb = 0, n;
    logic [31:0] d;
    logic [1:0]  r;
    typedef struct {logic [7:0] idx; logic [7:0] wv; logic [31:0] z; logic [31:0] rv;} row_t;
    row_t rows[8] = '{
        '{8'h18, 8'hA5, 32'h0, 32'hA5},   // on-time low byte
        '{8'h19, 8'h5A, 32'h0, 32'h5A},   // on-time high byte
        '{8'h1A, 8'h3C, 32'h0, 32'h3C},   // silent low byte
        '{8'h1B, 8'hC3, 32'h0, 32'hC3},   // silent high byte
        '{8'h65, 8'h12, 32'h0, 32'h12},
        '{8'h66, 8'h34, 32'h0, 32'h34},
        '{8'h17, 8'hFF, 32'h40, 32'h7B},  // read-only bits 7,6,2 ignore writes
        '{8'h04, 8'hFF, 32'h1, 32'h0}     // status is read-only
    };

    ring_cadence_ram_access_regs dut_u (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ring_request(ring_request),
        .ring_to_diff_converter(ring_to_diff_converter), .ring_out(ring_out),
        .pll_reinit(pll_reinit), .soft_reset_chan_b(soft_reset_chan_b)
    );

    always #50 clk = ~clk;

    // pulses are counted mid-cycle so the count never races the flops
    always @(negedge clk) begin
        n_pll += (pll_reinit === 1'b1);
        n_srb += (soft_reset_chan_b === 1'b1);
    end

    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_data

    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_resp

    // handshakes are judged at the falling edge, where inputs and outputs are settled
    task automatic axi_write(input logic [7:0] idx, input logic [7:0] v, input logic [3:0] st,
                             input logic [1:0] er);
        logic aw_hs, w_hs, b_hs;
        logic [1:0] got;
        awaddr  <= {22'h0, idx, 2'b00};
        wdata   <= {24'h0, v};
        wstrb   <= st;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        b_hs = 1'b0;
        while (!b_hs) begin
            @(negedge clk);
            aw_hs = awvalid & awready;
            w_hs  = wvalid & wready;
            b_hs  = bvalid;
            got   = bresp;
            @(posedge clk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        // bready stays high so a following call drives it only once per step
        chk_resp("bresp", er, got);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] idx, output logic [31:0] dv, output logic [1:0] rv);
        logic ar_hs, r_hs;
        araddr  <= {22'h0, idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        r_hs = 1'b0;
        while (!r_hs) begin
            @(negedge clk);
            ar_hs = arvalid & arready;
            r_hs  = rvalid;
            dv    = rdata;
            rv    = rresp;
            @(posedge clk);
            if (ar_hs) arvalid <= 1'b0;
        end
    endtask : axi_read

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        axi_write(idx, v, 4'hF, 2'b00);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] dv;
        logic [1:0]  rv;
        axi_read(idx, dv, rv);
        chk_data($sformatf("register %h", idx), e, dv);
        chk_resp("rresp", 2'b00, rv);
    endtask : rd

    task automatic wait_idle;
        logic [31:0] dv;
        logic [1:0]  rv;
        for (int k = 0; k < 300; k++) begin
            axi_read(8'h04, dv, rv);
            if (dv[0] === 1'b0) break;
        end
        chk_data("ram idle", 32'h0, dv);
    endtask : wait_idle

    // caller stands at a falling edge; counts cycles the oscillator keeps level lv
    task automatic span(input logic lv, output int cnt);
        cnt = 0;
        while (ring_out.osc_on === lv && cnt < 2000) begin
            cnt++;
            @(negedge clk);
        end
    endtask : span

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) rd(rows[i].idx, rows[i].z); // reset values, clear busy
        wait_idle;
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wv);
            rd(rows[i].idx, rows[i].rv);
        end
        chk_data("ring_out", 32'h7, {28'h0, ring_out});
        // write 0x3412 to word 0x10, zero to 0x11, then read 0x10 back alone
        // word 0x10 stands in for the ring offset coefficient, reverse polarity is selected
        wr(8'h67, 8'h10);
        wait_idle;
        wr(8'h65, 8'h00);
        wr(8'h66, 8'h00);
        wr(8'h67, 8'h11);
        wait_idle;
        wr(8'h67, 8'h10);
        wait_idle;
        rd(8'h65, 32'h12);
        rd(8'h66, 32'h34);
        rd(8'h67, 32'h10);
        axi_write(8'h65, 8'hEE, 4'hE, 2'b00);
        rd(8'h65, 32'h12);
        axi_write(8'h02, 8'h55, 4'hF, 2'b10);
        axi_read(8'h02, d, r);
        chk_data("unmapped data", 32'h0, d);
        chk_resp("unmapped resp", 2'b10, r);
        // cadence: 2 ticks on, 3 ticks off, 13 cycles a tick
        wr(8'h18, 8'h02);
        wr(8'h19, 8'h00);
        wr(8'h1A, 8'h03);
        wr(8'h1B, 8'h00);
        wr(8'h17, 8'h18);
        ring_request <= 1'b1;
        @(negedge clk);
        span(1'b0, n);
        @(posedge clk);
        rd(8'h17, 32'hDC);
        @(negedge clk);
        span(1'b1, n);
        span(1'b0, n);
        chk_data("silence cycles", 32'd39, n);
        span(1'b1, n);
        chk_data("burst cycles", 32'd26, n);
        @(posedge clk);
        ring_request <= 1'b0;
        rd(8'h17, 32'h58);
        // soft resets: B alone, A alone, then both
        wr(8'h01, 8'h02);
        rd(8'h17, 32'h58);
        chk_data("chan b pulses", 32'd1, n_srb);
        wr(8'h01, 8'h01);
        rd(8'h17, 32'h40);
        rd(8'h18, 32'h0);
        rd(8'h01, 32'h0);
        ring_to_diff_converter <= 1'b0;
        rd(8'h17, 32'h0);
        wr(8'h01, 8'h03);
        rd(8'h04, 32'h1);
        rd(8'h65, 32'h0);
        chk_data("pll pulses", 32'd1, n_pll);
        chk_data("chan b pulses", 32'd1, n_srb);
        wait_idle;
        // data byte is made nonzero first, so only a cleared word reads back as zero
        wr(8'h66, 8'hFF);
        wr(8'h67, 8'h20);
        wait_idle;
        wr(8'h67, 8'h10);
        wait_idle;
        rd(8'h66, 32'h0);
        stop_test;
    end

    // run is about 800 cycles; the 20000-cycle limit allows some 25 times that
    initial begin
        #2000000;
        n_mismatch++;
        stop_test;
    end
endmodule : test_ring_cadence_ram_access_regs
